// File: hw_loop_end_rule_checker_tb.sv
`timescale 1ns/100ps
module hw_loop_end_rule_checker_tb;
  import hwlc_pkg::*;
  localparam logic [19:0] CHANGE_OF_FLOW = 20'h1, CD = 20'h2, CB = 20'h4, SW = 20'h8;
  localparam logic [19:0] DI = 20'h10, DBG = 20'h20, LI = 20'h40;
  localparam logic [19:0] LID = 20'h80, LW = 20'h100, LR = 20'h200;
  localparam logic [19:0] SA = 20'h400, SRW = 20'h800, SRR = 20'h1000;
  localparam logic [19:0] DL = 20'h2000, DS = 20'h4000, EX = 20'h8000;
  localparam logic [19:0] SH = 20'h10000, MA = 20'h20000, MB = 20'h40000;
  localparam logic [19:0] DBL = 20'h80000;
  localparam int NR = 32;
  typedef struct {
    logic [19:0] p [4];
    logic [1:0] ix;
    logic [3:0] fl;
    logic [4:0] rule;
    int vp;
  } hwlc_row_t;
  hwlc_row_t rows [NR] = '{
    '{'{MB, 0, 0, 0}, 1, 0, 4, 0},
    '{'{MB, CHANGE_OF_FLOW, 0, 0}, 1, 2, 5, 1},
    '{'{MB, 0, SW, 0}, 1, 2, 5, 2},
    '{'{MB, DI, 0, 0}, 1, 2, 5, 1},
    '{'{MB, 0, DBG, 0}, 1, 2, 5, 2},
    '{'{MB, 0, LW, 0}, 1, 2, 6, 2},
    '{'{MB | LI, 0, 0, 0}, 1, 2, 6, 0},
    '{'{MB, LW, 0, 0}, 2, 6, 6, 1},
    '{'{MB, LW, 0, 0}, 1, 6, 0, 0},
    '{'{MA | SH | LR, 0, 0, 0}, 0, 2, 7, 0},
    '{'{MB | SH, SH | SRR, 0, 0}, 1, 2, 7, 1},
    '{'{MA | SH | CHANGE_OF_FLOW, 0, 0, 0}, 1, 2, 7, 0},
    '{'{MB | SH | LI, 0, 0, 0}, 1, 2, 7, 0},
    '{'{MB, 0, SRW, 0}, 1, 2, 8, 2},
    '{'{SH | SRW, SH, SH | MA, 0}, 1, 2, 9, 2},
    '{'{LI, MA, 0, 0}, 1, 2, 10, 1},
    '{'{LI | LID, 0, MA, 0}, 1, 2, 10, 2},
    '{'{LW, 0, MA, 0}, 1, 2, 10, 2},
    '{'{LI, 0, MA, 0}, 1, 2, 0, 0},
    '{'{SA, MB, 0, 0}, 1, 2, 11, 1},
    '{'{LR, MA, 0, 0}, 1, 2, 12, 1},
    '{'{LR, MA, 0, 0}, 0, 2, 0, 0},
    '{'{MB | CHANGE_OF_FLOW, 0, 0, 0}, 1, 2, 13, 0},
    '{'{CB, MA, 0, 0}, 1, 2, 14, 1},
    '{'{MB | DL, MA, 0, 0}, 1, 2, 15, 1},
    '{'{MA | DS, 0, 0, 0}, 1, 2, 16, 0},
    '{'{CD, MA, 0, 0}, 1, 2, 17, 1},
    '{'{SRR, MB, 0, 0}, 1, 2, 18, 1},
    '{'{EX, MA, 0, 0}, 1, 2, 19, 1},
    '{'{EX, 0, MA, 0}, 1, 2, 0, 0},
    '{'{MA | DBL, 0, 0, 0}, 1, 2, 20, 0},
    '{'{MA, 0, 0, 0}, 1, 2, 0, 0}
  };
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [HWLC_AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, pkt_valid, viol_flag;
  logic [31:0] pkt_addr;
  logic [15:0] pkt_prefix;
  logic [1:0] mark_a_count, mark_b_count;
  logic [HWLC_NLOOP-1:0] loop_enable_flag;
  logic [16:0] ops;
  logic [HWLC_IW-1:0] op_idx;
  int mismatches = 0;
  int cmp_count = 0;

  always #50 pclk = ~pclk;

  hwlc_pkt_src src (.pclk(pclk), .pkt_valid(pkt_valid),
    .pkt_addr(pkt_addr), .pkt_prefix(pkt_prefix),
    .mark_a_count(mark_a_count), .mark_b_count(mark_b_count),
    .loop_enable_flag(loop_enable_flag), .ops(ops), .op_idx(op_idx));

  hwlc_checker uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_valid(pkt_valid), .pkt_addr(pkt_addr), .pkt_prefix(pkt_prefix),
    .mark_a_count(mark_a_count), .mark_b_count(mark_b_count),
    .loop_enable_flag(loop_enable_flag), .short_loop(ops[16]),
    .op_cof(ops[0]), .op_cof_delayed(ops[1]), .op_cond_br(ops[2]),
    .op_stop_wait(ops[3]), .op_di(ops[4]), .op_debug(ops[5]),
    .op_lc_init(ops[6]), .op_lc_init_data(ops[7]), .op_lc_mv_wr(ops[8]),
    .op_lc_mv_rd(ops[9]), .op_lc_idx(op_idx), .op_sa_wr(ops[10]),
    .op_sa_idx(op_idx), .op_sr_wr(ops[11]), .op_sr_rd(ops[12]),
    .cof_dest_loop(ops[13]), .cof_dest_subr(ops[14]),
    .exc_first(ops[15]), .viol_flag(viol_flag));

  function automatic logic [31:0] ad(input int i, input int k);
    return 32'(32'h1000 + i * 16 + k * 4);
  endfunction : ad

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Starts just after a rising edge and returns one edge after release, so
  // back-to-back calls never drive psel twice in one time step.
  task automatic apb(input logic w, input logic [HWLC_AW-1:0] a,
      input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      results();
    end
    @(posedge pclk);
  endtask : apb

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, HWLC_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, HWLC_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, viol_flag}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    $display("reset and map test done");
    for (int i = 0; i < NR; i++) begin
      apb(1'b1, HWLC_OFS_STATUS, 32'h1);
      for (int k = 0; k < 2; k++) src.send(32'h800, 20'h0, rows[i].ix,
          rows[i].fl);
      for (int k = 0; k < 4; k++) src.send(ad(i, k), rows[i].p[k],
          rows[i].ix, rows[i].fl);
      src.idle();
      apb(1'b0, HWLC_OFS_STATUS, 32'h0);
      chk(rd, {31'h0, rows[i].rule != 0});
      chk({31'h0, viol_flag}, {31'h0, rows[i].rule != 0});
      if (rows[i].rule != 0) begin
        apb(1'b0, HWLC_OFS_RULE, 32'h0);
        chk(rd, {27'h0, rows[i].rule});
        apb(1'b0, HWLC_OFS_VADDR, 32'h0);
        chk(rd, ad(i, rows[i].vp));
      end
      $display("row %0d done", i);
    end
    apb(1'b1, HWLC_OFS_CTRL, 32'h0);
    apb(1'b1, HWLC_OFS_STATUS, 32'h1);
    src.send(32'h900, MB, 2'h1, 4'h2);
    src.send(32'h904, CHANGE_OF_FLOW, 2'h1, 4'h2);
    src.idle();
    apb(1'b0, HWLC_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, HWLC_OFS_CTRL, 32'h1);
    $display("disable test done");
    src.send(32'h908, MB, 2'h0, 4'h6);
    src.idle();
    apb(1'b0, HWLC_OFS_LOOP, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, HWLC_OFS_VADDR, 32'h0);
    apb(1'b0, HWLC_OFS_VADDR, 32'h0);
    chk(rd, ad(30, 0));
    $display("loop and read-only test done");
    // A violation on the very edge that clears the flag must keep it set.
    fork
      apb(1'b1, HWLC_OFS_STATUS, 32'h1);
      begin
        @(posedge pclk);
        src.send(32'ha00, MB, 2'h0, 4'h0);
        src.idle();
      end
    join
    chk({31'h0, viol_flag}, 32'h1);
    apb(1'b0, HWLC_OFS_VADDR, 32'h0);
    chk(rd, 32'ha00);
    $display("set-wins test done");
    apb(1'b1, HWLC_OFS_CTRL, 32'h0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({30'h0, pready, viol_flag}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, HWLC_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, HWLC_OFS_RULE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, HWLC_OFS_VADDR, 32'h0);
    chk(rd, 32'h0);
    $display("mid-run reset test done");
    results();
  end
endmodule : hw_loop_end_rule_checker_tb

// File: hwlc_active_loop.sv
`timescale 1ns/100ps
module hwlc_active_loop
  import hwlc_pkg::*;
(
  input wire logic [HWLC_NLOOP-1:0] flags,
  output logic [HWLC_IW-1:0] idx,
  output logic any
);
  always_comb begin
    idx = '0;
    any = |flags;
    for (int i = 0; i < HWLC_NLOOP; i++) begin
      if (flags[i]) begin
        idx = HWLC_IW'(i);
      end
    end
  end
endmodule : hwlc_active_loop

// File: hwlc_checker.sv
// Function
// - Loop ends are recognised from two end-mark bits in the first prefix.
// - Active loop is the enabled loop with highest index at mark time.
// - Active counter and start-address registers follow the active index.
// - Flag a mark packet executed while no loop enable flag is set.
// - Long loop: no flow change, stop, wait, disable, debug in the two packets after mark-B.
// - Long loop: no active counter write at mark-B or two packets after.
// - Short loop: restricted instruction set at mark-A, mark-B, mark-B+1.
// - Long loop: no status write from mark-B-2 through mark-B+2.
// - Short loop: no status write in two packets before a mark.
// - Counter write needs one or two packets before a mark.
// - Long loop: start-address write needs one packet before a mark.
// - Active counter read needs one packet before a mark.
// - Long loop: no flow change inside the mark-B packet.
// - No conditional branch or jump just before a mark packet.
// - Loop flow change may not land on long mark-B followed by mark-A.
// - Subroutine calls may not land on a mark packet.
// - No delayed flow change just before a mark packet.
// - Status read needs one packet before a mark.
// - No mark in the first two packets of an exception routine.
// - At most one mark-A and one mark-B per packet.
// - Marks act regardless of conditional prefix or position.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module hwlc_checker
  import hwlc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [HWLC_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pkt_valid,
  input wire logic [31:0] pkt_addr,
  input wire logic [15:0] pkt_prefix,
  input wire logic [1:0] mark_a_count,
  input wire logic [1:0] mark_b_count,
  input wire logic [HWLC_NLOOP-1:0] loop_enable_flag,
  input wire logic short_loop,
  input wire logic op_cof,
  input wire logic op_cof_delayed,
  input wire logic op_cond_br,
  input wire logic op_stop_wait,
  input wire logic op_di,
  input wire logic op_debug,
  input wire logic op_lc_init,
  input wire logic op_lc_init_data,
  input wire logic op_lc_mv_wr,
  input wire logic op_lc_mv_rd,
  input wire logic [HWLC_IW-1:0] op_lc_idx,
  input wire logic op_sa_wr,
  input wire logic [HWLC_IW-1:0] op_sa_idx,
  input wire logic op_sr_wr,
  input wire logic op_sr_rd,
  input wire logic cof_dest_loop,
  input wire logic cof_dest_subr,
  input wire logic exc_first,
  output logic viol_flag
);
  logic [HWLC_IW-1:0] act_idx;
  logic act_any;
  logic mark_a, mark_b, mark, long_loop, barred;
  logic [HWLC_HW-1:0] cur_h;
  logic [HWLC_NRULE-1:0] v;
  logic hit;
  logic [HWLC_RW-1:0] first_rule;
  logic m_c, m_1, m_2;
  logic [HWLC_HW-1:0] h1_reg, h1_next, h2_reg, h2_next;
  logic [HWLC_IW-1:0] h1_lc_reg, h1_lc_next, h2_lc_reg, h2_lc_next;
  logic [HWLC_IW-1:0] h1_sa_reg, h1_sa_next;
  hwlc_post_t post_reg, post_next;
  logic post_long_reg, post_long_next;
  logic [HWLC_IW-1:0] post_idx_reg, post_idx_next;
  logic pend15_reg, pend15_next, exc2_reg, exc2_next;
  logic ctrl_en_reg, ctrl_en_next, stat_reg, stat_next;
  logic [31:0] vaddr_reg, vaddr_next;
  logic [HWLC_RW-1:0] rule_reg, rule_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic access, wr_stat_clr;

  hwlc_active_loop u_act (
    .flags(loop_enable_flag),
    .idx(act_idx),
    .any(act_any)
  );

  // Marks come straight from the prefix bits; any conditional prefix in the
  // packet is deliberately not consulted.
  always_comb begin
    mark_a = pkt_valid & pkt_prefix[HWLC_PFX_MARK_A];
    mark_b = pkt_valid & pkt_prefix[HWLC_PFX_MARK_B];
    mark = mark_a | mark_b;
    long_loop = ~short_loop;
    barred = op_cof | op_stop_wait | op_di | op_debug;
    cur_h = '0;
    cur_h[HWLC_H_CONDBR] = op_cond_br;
    cur_h[HWLC_H_COFD] = op_cof_delayed;
    cur_h[HWLC_H_SRWR] = op_sr_wr;
    cur_h[HWLC_H_SRRD] = op_sr_rd;
    cur_h[HWLC_H_LCFAST] = op_lc_init & ~op_lc_init_data;
    cur_h[HWLC_H_LCSLOW] = (op_lc_init & op_lc_init_data) | op_lc_mv_wr;
    cur_h[HWLC_H_LCRD] = op_lc_mv_rd;
    cur_h[HWLC_H_SAWR] = op_sa_wr;
    // Register indices are compared with the loop active at mark time.
    m_c = (op_lc_idx == act_idx);
    m_1 = (h1_lc_reg == act_idx);
    m_2 = (h2_lc_reg == act_idx);
  end

  always_comb begin
    v = '0;
    v[4] = mark & ~act_any;
    v[5] = pkt_valid & post_long_reg & (post_reg != HWLC_POST_IDLE)
           & barred;
    v[6] = (mark_b & long_loop & (op_lc_init | op_lc_mv_wr) & m_c)
         | (pkt_valid & post_long_reg & (post_reg != HWLC_POST_IDLE)
            & (op_lc_init | op_lc_mv_wr) & (op_lc_idx == post_idx_reg));
    v[7] = ((mark & short_loop)
           | (pkt_valid & ~post_long_reg & (post_reg == HWLC_POST_B1)))
         & (barred | op_lc_init | op_lc_mv_wr | op_lc_mv_rd
            | op_sr_wr | op_sr_rd);
    v[8] = (mark_b & long_loop & (op_sr_wr | h1_reg[HWLC_H_SRWR]
            | h2_reg[HWLC_H_SRWR]))
         | (pkt_valid & post_long_reg & (post_reg != HWLC_POST_IDLE)
            & op_sr_wr);
    v[9] = mark & short_loop
         & (h1_reg[HWLC_H_SRWR] | h2_reg[HWLC_H_SRWR]);
    v[10] = mark & ((((cur_h[HWLC_H_LCFAST] | cur_h[HWLC_H_LCSLOW]) & m_c)
            | ((h1_reg[HWLC_H_LCFAST] | h1_reg[HWLC_H_LCSLOW]) & m_1)
            | (h2_reg[HWLC_H_LCSLOW] & m_2)));
    v[11] = mark & long_loop & ((op_sa_wr & (op_sa_idx == act_idx))
            | (h1_reg[HWLC_H_SAWR] & (h1_sa_reg == act_idx)));
    v[12] = mark & ((op_lc_mv_rd & m_c)
            | (h1_reg[HWLC_H_LCRD] & m_1));
    v[13] = mark_b & long_loop & op_cof;
    v[14] = mark & h1_reg[HWLC_H_CONDBR];
    v[15] = pend15_reg & mark_a;
    v[16] = mark & cof_dest_subr;
    v[17] = mark & h1_reg[HWLC_H_COFD];
    v[18] = mark & (op_sr_rd | h1_reg[HWLC_H_SRRD]);
    v[19] = mark & (exc_first | exc2_reg);
    v[20] = pkt_valid & ((mark_a_count > HWLC_MARK_MAX)
            | (mark_b_count > HWLC_MARK_MAX));
  end

  // The lowest-numbered broken rule is the one reported.
  always_comb begin
    hit = ctrl_en_reg & (|v);
    first_rule = '0;
    for (int i = HWLC_NRULE - 1; i > 0; i--) begin
      if (v[i]) begin
        first_rule = HWLC_RW'(i);
      end
    end
  end

  always_comb begin
    h1_next = h1_reg;
    h2_next = h2_reg;
    h1_lc_next = h1_lc_reg;
    h2_lc_next = h2_lc_reg;
    h1_sa_next = h1_sa_reg;
    post_next = post_reg;
    post_long_next = post_long_reg;
    post_idx_next = post_idx_reg;
    pend15_next = pend15_reg;
    exc2_next = exc2_reg;
    if (pkt_valid) begin
      h1_next = cur_h;
      h2_next = h1_reg;
      h1_lc_next = op_lc_idx;
      h2_lc_next = h1_lc_reg;
      h1_sa_next = op_sa_idx;
      // A loop flow change landing on long mark-B waits for the next packet.
      pend15_next = mark_b & long_loop & cof_dest_loop;
      exc2_next = exc_first;
      if (mark_b) begin
        post_next = HWLC_POST_B1;
        post_long_next = long_loop;
        post_idx_next = act_idx;
      end else begin
        case (post_reg)
          HWLC_POST_B1: post_next = post_long_reg ? HWLC_POST_B2
                                                  : HWLC_POST_IDLE;
          HWLC_POST_B2: post_next = HWLC_POST_IDLE;
          default: post_next = HWLC_POST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h1_reg <= '0;
      h2_reg <= '0;
      h1_lc_reg <= '0;
      h2_lc_reg <= '0;
      h1_sa_reg <= '0;
      post_reg <= HWLC_POST_IDLE;
      post_long_reg <= 1'b0;
      post_idx_reg <= '0;
      pend15_reg <= 1'b0;
      exc2_reg <= 1'b0;
    end else begin
      h1_reg <= h1_next;
      h2_reg <= h2_next;
      h1_lc_reg <= h1_lc_next;
      h2_lc_reg <= h2_lc_next;
      h1_sa_reg <= h1_sa_next;
      post_reg <= post_next;
      post_long_reg <= post_long_next;
      post_idx_reg <= post_idx_next;
      pend15_reg <= pend15_next;
      exc2_reg <= exc2_next;
    end
  end

  // One wait state per transfer keeps read data registered.
  always_comb begin
    access = psel & penable & ~pready_reg;
    wr_stat_clr = access & pwrite & (paddr == HWLC_OFS_STATUS)
                & pwdata[HWLC_STAT_VIOL_BIT];
    ctrl_en_next = ctrl_en_reg;
    pready_next = access;
    pslverr_next = 1'b0;
    prdata_next = '0;
    if (access) begin
      case (paddr)
        HWLC_OFS_CTRL: begin
          prdata_next[HWLC_CTRL_EN_BIT] = ctrl_en_reg;
          if (pwrite) begin
            ctrl_en_next = pwdata[HWLC_CTRL_EN_BIT];
          end
        end
        HWLC_OFS_STATUS: prdata_next[HWLC_STAT_VIOL_BIT] = stat_reg;
        HWLC_OFS_VADDR: prdata_next = vaddr_reg;
        HWLC_OFS_RULE: prdata_next[HWLC_RW-1:0] = rule_reg;
        HWLC_OFS_LOOP: begin
          prdata_next[HWLC_IW-1:0] = act_idx;
          prdata_next[HWLC_LOOP_ANY_BIT] = act_any;
        end
        default: pslverr_next = 1'b1;
      endcase
      if (!pwrite) begin
        prdata_next = pslverr_next ? '0 : prdata_next;
      end else begin
        prdata_next = '0;
      end
    end
    // A new violation outranks a clear in the same cycle.
    stat_next = hit | (stat_reg & ~wr_stat_clr);
    vaddr_next = hit ? pkt_addr : vaddr_reg;
    rule_next = hit ? first_rule : rule_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_reg <= HWLC_CTRL_EN_RST;
      stat_reg <= 1'b0;
      vaddr_reg <= '0;
      rule_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      ctrl_en_reg <= ctrl_en_next;
      stat_reg <= stat_next;
      vaddr_reg <= vaddr_next;
      rule_reg <= rule_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign viol_flag = stat_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_NO_LOOP_FLAG: assert property (
    mark & ~(|loop_enable_flag) & ctrl_en_reg
    |=> stat_reg && rule_reg == 5'h04)
    else $error("mark without enabled loop not reported");
  AST_TOP_LOOP: assert property (
    loop_enable_flag[HWLC_NLOOP-1] |-> act_idx == 2'h3 && act_any)
    else $error("active loop is not the highest enabled one");
  AST_SA_ACTIVE: assert property (
    mark & ~short_loop & op_sa_wr & (op_sa_idx == act_idx) & ctrl_en_reg
    |=> stat_reg)
    else $error("active start-address write at mark not reported");
  AST_POST_B: assert property (
    mark_b & ~short_loop ##1 pkt_valid & ~mark_b
    |=> post_reg == HWLC_POST_B2)
    else $error("packet position after mark-B lost");
  AST_AFTER_B_COF: assert property (
    (post_reg == HWLC_POST_B2) & post_long_reg & pkt_valid & op_cof
    & ctrl_en_reg |=> stat_reg)
    else $error("flow change two packets after mark-B not reported");
  AST_CONDBR_BEFORE: assert property (
    pkt_valid & op_cond_br ##1 mark & ctrl_en_reg |=> stat_reg)
    else $error("conditional branch before mark not reported");
  AST_LC_DATA_INIT: assert property (
    pkt_valid & op_lc_init & op_lc_init_data & (op_lc_idx == act_idx)
    & $stable(loop_enable_flag) ##1 pkt_valid & $stable(loop_enable_flag)
    ##1 mark & ctrl_en_reg & $stable(loop_enable_flag) |=> stat_reg)
    else $error("slow counter write two packets before mark missed");
  AST_DOUBLE_MARK: assert property (
    pkt_valid & (mark_a_count > 2'h1) & ctrl_en_reg
    |=> stat_reg && rule_reg <= 5'h14)
    else $error("repeated mark in one packet not reported");
  AST_EXC_SECOND: assert property (
    pkt_valid & exc_first ##1 mark & ctrl_en_reg
    |=> stat_reg && rule_reg <= 5'h13)
    else $error("mark as second exception packet not reported");
  AST_STICKY: assert property (
    stat_reg & ~wr_stat_clr |=> stat_reg)
    else $error("violation flag dropped without a clear");
  AST_SET_WINS: assert property (
    hit & wr_stat_clr |=> stat_reg && vaddr_reg == $past(pkt_addr))
    else $error("clear beat a simultaneous violation");
  AST_APB_ONE_WAIT: assert property (
    psel & penable & ~pready_reg |=> pready_reg ##1 ~pready_reg)
    else $error("apb answer not after exactly one wait state");

  COV_LONG_TAIL: cover property (
    mark_b & ~short_loop ##1 pkt_valid ##1 pkt_valid);
  COV_SHORT_VIOL: cover property (mark & short_loop & op_sr_rd ##1 stat_reg);
  COV_CLEAR: cover property (stat_reg ##1 wr_stat_clr ##1 ~stat_reg);
  COV_PEND15: cover property (pend15_reg & mark_a);
endmodule : hwlc_checker

// File: hwlc_pkg.sv
package hwlc_pkg;
  localparam int HWLC_NLOOP = 4;
  localparam int HWLC_IW = 2;
  localparam int HWLC_NRULE = 22;
  localparam int HWLC_RW = 5;
  localparam int HWLC_AW = 8;
  // Register byte offsets on the APB bus.
  localparam logic [HWLC_AW-1:0] HWLC_OFS_CTRL = 8'h00;
  localparam logic [HWLC_AW-1:0] HWLC_OFS_STATUS = 8'h04;
  localparam logic [HWLC_AW-1:0] HWLC_OFS_VADDR = 8'h08;
  localparam logic [HWLC_AW-1:0] HWLC_OFS_RULE = 8'h0c;
  localparam logic [HWLC_AW-1:0] HWLC_OFS_LOOP = 8'h10;
  localparam int HWLC_CTRL_EN_BIT = 0;
  localparam int HWLC_STAT_VIOL_BIT = 0;
  localparam int HWLC_LOOP_ANY_BIT = 2;
  localparam logic HWLC_CTRL_EN_RST = 1'h1;
  // Loop end-mark bit positions in the first prefix word.
  localparam int HWLC_PFX_MARK_A = 0;
  localparam int HWLC_PFX_MARK_B = 1;
  localparam logic [1:0] HWLC_MARK_MAX = 2'h1;
  // Per-packet history attribute bit positions.
  localparam int HWLC_H_CONDBR = 0;
  localparam int HWLC_H_COFD = 1;
  localparam int HWLC_H_SRWR = 2;
  localparam int HWLC_H_SRRD = 3;
  localparam int HWLC_H_LCFAST = 4;
  localparam int HWLC_H_LCSLOW = 5;
  localparam int HWLC_H_LCRD = 6;
  localparam int HWLC_H_SAWR = 7;
  localparam int HWLC_HW = 8;
  typedef enum logic [1:0] {
    HWLC_POST_IDLE = 2'b00,
    HWLC_POST_B1 = 2'b01,
    HWLC_POST_B2 = 2'b10
  } hwlc_post_t;
endpackage : hwlc_pkg

// File: hwlc_pkt_src.sv
`timescale 1ns/100ps
module hwlc_pkt_src
  import hwlc_pkg::*;
(
  input wire logic pclk,
  output logic pkt_valid,
  output logic [31:0] pkt_addr,
  output logic [15:0] pkt_prefix,
  output logic [1:0] mark_a_count,
  output logic [1:0] mark_b_count,
  output logic [HWLC_NLOOP-1:0] loop_enable_flag,
  output logic [16:0] ops,
  output logic [HWLC_IW-1:0] op_idx
);
  initial begin
    pkt_valid = 1'b0;
    pkt_addr = 32'h0;
    pkt_prefix = 16'h0;
    mark_a_count = 2'h0;
    mark_b_count = 2'h0;
    loop_enable_flag = '0;
    ops = 17'h0;
    op_idx = '0;
  end
  // Word w: bits 16:0 instruction kinds, 17 mark-A, 18 mark-B, 19 doubled
  // mark-A. Upper prefix bits carry junk so marks must be read by position.
  task automatic send(input logic [31:0] a, input logic [19:0] w,
      input logic [HWLC_IW-1:0] ix, input logic [HWLC_NLOOP-1:0] fl);
    pkt_valid <= 1'b1;
    pkt_addr <= a;
    pkt_prefix <= {a[15:2], w[18:17]};
    mark_a_count <= w[19] ? 2'h2 : {1'b0, w[17]};
    mark_b_count <= {1'b0, w[18]};
    loop_enable_flag <= fl;
    ops <= w[16:0];
    op_idx <= ix;
    @(posedge pclk);
  endtask : send
  // Between packets the qualified fields are inverted, never left stale;
  // the loop flags are a level and hold.
  task automatic idle();
    pkt_valid <= 1'b0;
    pkt_addr <= ~pkt_addr;
    pkt_prefix <= ~pkt_prefix;
    mark_a_count <= ~mark_a_count;
    mark_b_count <= ~mark_b_count;
    ops <= ~ops;
    op_idx <= ~op_idx;
    @(posedge pclk);
  endtask : idle
endmodule : hwlc_pkt_src
